//--- led_drv_pkg.sv
// package of constants and carrier types for the led boost enable and dimming control
package led_drv_pkg;

  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ          = 100;        // core clock rate
  localparam int EN_QUAL_US       = 50;         // high time that enables
  localparam int SHDN_QUAL_MS     = 32;         // low time that shuts down
  localparam int BLANK_NS         = 400;        // comparator blanking after close
  localparam int MAX_ON_NS        = 6000;       // main switch longest on-time
  localparam int MIN_OFF_NS       = 400;        // main switch least off-time
  // longest times round down, least times round up
  localparam int EN_QUAL_CYC      = (EN_QUAL_US * CLK_MHZ);
  localparam int SHDN_QUAL_CYC    = (SHDN_QUAL_MS * 1000 * CLK_MHZ);
  localparam int BLANK_CYC        = (BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int MAX_ON_CYC       = (MAX_ON_NS * CLK_MHZ) / 1000;
  localparam int MIN_OFF_CYC      = (MIN_OFF_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------------
  // soft-start
  // ----------------------------------------------------------------------
  localparam int SS_STEP_CYCLES   = 256;        // switch cycles per step
  localparam int SS_DONE_CYCLES   = 512;        // switch cycles to completion
  localparam int SS_CNT_W         = 10;         // width of the switch cycle counter

  // current limit code driven to the analog limiter
  localparam logic [1:0] LIM_QUARTER = 2'h1;    // one quarter of full limit
  localparam logic [1:0] LIM_HALF    = 2'h2;    // one half of full limit
  localparam logic [1:0] LIM_FULL    = 2'h3;    // full limit
  localparam logic [1:0] LIM_OFF     = 2'h0;    // no limit granted, converter idle

  // ----------------------------------------------------------------------
  // operating states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_SHUTDOWN,
    ST_QUALIFY,
    ST_ENABLED
  } op_state_t;

  // analog comparator inputs, all from outside the clock domain
  typedef struct packed {
    logic ctrl;         // control input level
    logic feedback_low; // feedback_sense below reference
    logic peak_reached; // switch current at switch_current_limit
    logic overvoltage;  // overvoltage_sense above threshold
    logic undervoltage; // supply below lockout threshold
    logic overtemp;     // junction above thermal threshold
  } sense_t;

endpackage

//--- led_main_switch.sv
// main power switch on/off timing: peak, max-on, min-off and feedback start
`timescale 1ns/1ps
`default_nettype none
module led_main_switch
  import led_drv_pkg::*;
#(
  parameter int MAX_ON  = MAX_ON_CYC,
  parameter int MIN_OFF = MIN_OFF_CYC
)(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic run,          // converter allowed to switch
  input  wire logic start_ok,     // feedback low and not blanked
  input  wire logic peak_reached, // current at limit
  input  wire logic overvoltage,  // output above threshold
  output logic      sw_on,        // main switch gate
  output logic      cycle_pulse   // one pulse per completed on-period
);

  // ----------------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------------
  localparam int TW = $clog2(MAX_ON + 1);
  localparam logic [TW-1:0] MAX_ON_T  = TW'(MAX_ON);
  localparam logic [TW-1:0] MIN_OFF_T = TW'(MIN_OFF);

  logic [TW-1:0] on_cnt_q;   // cycles since turn-on
  logic [TW-1:0] off_cnt_q;  // cycles since turn-off, saturating
  logic          off_done;   // least off-time has passed
  logic          turn_off;   // any reason to end the on-period
  logic          turn_on;    // every condition to begin one

  assign off_done = (off_cnt_q >= MIN_OFF_T);
  // peak current, max on-time, overvoltage or loss of run all end the pulse
  assign turn_off = sw_on & (peak_reached |
                             (on_cnt_q >= MAX_ON_T - TW'(1)) |
                             overvoltage | ~run);
  assign turn_on  = ~sw_on & run & ~overvoltage & start_ok & off_done;

  // ----------------------------------------------------------------------
  // switch state and counters
  // ----------------------------------------------------------------------
  // off counter starts full so the first pulse after enable is not delayed
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sw_on       <= 1'b0;
      on_cnt_q    <= '0;
      off_cnt_q   <= MIN_OFF_T;
      cycle_pulse <= 1'b0;
    end
    else if (ce)
    begin
      cycle_pulse <= turn_off;
      if (turn_off)
      begin
        sw_on     <= 1'b0;
        off_cnt_q <= '0;
      end
      else if (turn_on)
      begin
        sw_on    <= 1'b1;
        on_cnt_q <= '0;
      end
      else if (sw_on)
        on_cnt_q <= on_cnt_q + TW'(1);
      else if (!off_done)
        off_cnt_q <= off_cnt_q + TW'(1);
    end
  end

endmodule
`default_nettype wire

//--- led_boost_ctrl.sv
// top of the led boost driver digital control: enable, dimming, soft-start, faults
`timescale 1ns/1ps
`default_nettype none

module led_boost_ctrl
  import led_drv_pkg::*;
#(
  parameter int EN_QUAL   = EN_QUAL_CYC,
  parameter int SHDN_QUAL = SHDN_QUAL_CYC,
  parameter int BLANK     = BLANK_CYC
)(
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       CE,
  input  wire sense_t     SENSE,
  output logic            MAIN_POWER_SWITCH,
  output logic            LED_RETURN_SWITCH,
  output logic [1:0]      SWITCH_CURRENT_LIMIT,
  output logic            ENABLED,
  output logic            SOFTSTART_DONE
);

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  sense_t sync1_q;     // first stage, read only by the second
  sense_t sync2_q;     // clean copy in the clock domain
  logic   ctrl_prev_q; // last synchronised control level

  // two flops per comparator, the inputs are asynchronous to CLK
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      sync1_q     <= '0;
      sync2_q     <= '0;
      ctrl_prev_q <= 1'b0;
    end
    else if (CE)
    begin
      sync1_q     <= SENSE;
      sync2_q     <= sync1_q;
      ctrl_prev_q <= sync2_q.ctrl;
    end
  end

  wire ctrl      = sync2_q.ctrl;
  wire ctrl_rise = ctrl & ~ctrl_prev_q;
  wire fault     = sync2_q.undervoltage | sync2_q.overtemp;

  // ----------------------------------------------------------------------
  // enable / shutdown qualification
  // ----------------------------------------------------------------------
  localparam int QW = $clog2(SHDN_QUAL + 1);
  localparam logic [QW-1:0] EN_T   = QW'(EN_QUAL);
  localparam logic [QW-1:0] SHDN_T = QW'(SHDN_QUAL);

  op_state_t     state_q;   // operating state
  op_state_t     state_d;
  logic [QW-1:0] qual_q;    // length of the current control level
  logic          en_met;    // high long enough
  logic          shdn_met;  // low long enough

  assign en_met   = (qual_q >= EN_T - QW'(1)) & ctrl;
  assign shdn_met = (qual_q >= SHDN_T - QW'(1)) & ~ctrl;

  // next state: faults win over the control input
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_SHUTDOWN: if (ctrl && !fault) state_d = ST_QUALIFY;
      ST_QUALIFY:  if (!ctrl || fault) state_d = ST_SHUTDOWN;
                   else if (en_met)     state_d = ST_ENABLED;
      ST_ENABLED:  if (fault || shdn_met) state_d = ST_SHUTDOWN;
      // the unused fourth code falls back to the safe state
      default:     state_d = ST_SHUTDOWN;
    endcase
  end

  // the level counter restarts on every control edge; a narrow pulse or gap
  // therefore never adds up towards either qualification; a fault also clears
  // it, so control held high through a lockout must qualify again afterwards
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state_q <= ST_SHUTDOWN;
      qual_q  <= '0;
    end
    else if (CE)
    begin
      state_q <= state_d;
      if ((ctrl != ctrl_prev_q) || fault)
        qual_q <= '0;
      else if (qual_q != SHDN_T)
        qual_q <= qual_q + QW'(1);
    end
  end

  wire enabled = (state_q == ST_ENABLED) & ~fault;

  // ----------------------------------------------------------------------
  // soft-start switch cycle counter
  // ----------------------------------------------------------------------
  localparam logic [SS_CNT_W-1:0] SS_STEP = SS_CNT_W'(SS_STEP_CYCLES);
  localparam logic [SS_CNT_W-1:0] SS_DONE = SS_CNT_W'(SS_DONE_CYCLES);

  logic [SS_CNT_W-1:0] ss_cnt_q;  // completed switch cycles since enable
  logic                cycle_pulse;
  logic                ss_done;
  logic [1:0]          limit_d;

  assign ss_done = (ss_cnt_q >= SS_DONE);
  // step the limit up with the cycle count
  assign limit_d = !enabled           ? LIM_OFF :
                   (ss_cnt_q < SS_STEP) ? LIM_QUARTER :
                   !ss_done           ? LIM_HALF : LIM_FULL;

  // counter cleared whenever not enabled, so a re-enable starts from step one
  always_ff @(posedge CLK)
  begin
    if (RST)
      ss_cnt_q <= '0;
    else if (CE)
    begin
      if (!enabled)
        ss_cnt_q <= '0;
      else if (cycle_pulse && !ss_done)
        ss_cnt_q <= ss_cnt_q + SS_CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------------
  // led return switch and comparator blanking
  // ----------------------------------------------------------------------
  localparam int BW = $clog2(BLANK + 1);
  localparam logic [BW-1:0] BLANK_T = BW'(BLANK);

  logic [BW-1:0] blank_q;   // cycles of blanking left
  logic          led_d;
  logic          led_close;

  // follows the synchronised level; a rise closes it with no qualification
  assign led_d     = enabled & ctrl;
  assign led_close = led_d & ~LED_RETURN_SWITCH;

  // blanking reloads at each close so the sense node can settle
  always_ff @(posedge CLK)
  begin
    if (RST)
      blank_q <= '0;
    else if (CE)
    begin
      if (led_close || (enabled && ctrl_rise))
        blank_q <= BLANK_T;
      else if (blank_q != '0)
        blank_q <= blank_q - BW'(1);
    end
  end

  wire start_ok = sync2_q.feedback_low & (blank_q == '0) & LED_RETURN_SWITCH;

  // ----------------------------------------------------------------------
  // main switch timing
  // ----------------------------------------------------------------------
  logic main_on;

  led_main_switch u_main (
    .clk          (CLK),
    .rst          (RST),
    .ce           (CE),
    .run          (enabled),
    .start_ok     (start_ok),
    .peak_reached (sync2_q.peak_reached),
    .overvoltage  (sync2_q.overvoltage),
    .sw_on        (main_on),
    .cycle_pulse  (cycle_pulse)
  );

  // ----------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------
  // main gate re-registered and masked so a fault opens it within one edge
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      MAIN_POWER_SWITCH    <= 1'b0;
      LED_RETURN_SWITCH    <= 1'b0;
      SWITCH_CURRENT_LIMIT <= LIM_OFF;
      ENABLED              <= 1'b0;
      SOFTSTART_DONE       <= 1'b0;
    end
    else if (CE)
    begin
      MAIN_POWER_SWITCH    <= main_on & enabled & ~sync2_q.overvoltage;
      LED_RETURN_SWITCH    <= led_d;
      SWITCH_CURRENT_LIMIT <= limit_d;
      ENABLED              <= enabled;
      SOFTSTART_DONE       <= enabled & ss_done;
    end
  end

endmodule
`default_nettype wire

//--- led_boost_ctrl_assertions.sv
// port checker for the led boost enable and dimming control
`timescale 1ns/1ps
`default_nettype none
module led_boost_ctrl_assertions
  import led_drv_pkg::*;
#(
  parameter int EN_QUAL   = EN_QUAL_CYC,
  parameter int SHDN_QUAL = SHDN_QUAL_CYC,
  parameter int BLANK     = BLANK_CYC
)(
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       CE,
  input wire sense_t     SENSE,
  input wire logic       MAIN_POWER_SWITCH,
  input wire logic       LED_RETURN_SWITCH,
  input wire logic [1:0] SWITCH_CURRENT_LIMIT,
  input wire logic       ENABLED,
  input wire logic       SOFTSTART_DONE
);
  // ------------------------------------------------------------
  // main switch run lengths
  // ------------------------------------------------------------
  logic [15:0] on_q;  // cycles on so far
  logic [15:0] off_q; // cycles off so far, saturating
  // reset counts as a long off time, so the first turn-on is legal
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      on_q  <= 16'h0000;
      off_q <= 16'hFFFF;
    end
    else if (CE)
    begin
      on_q  <= MAIN_POWER_SWITCH ? on_q + 16'h0001 : 16'h0000;
      off_q <= MAIN_POWER_SWITCH ? 16'h0000 : off_q + {15'h0000, off_q != 16'hFFFF};
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence led_close;
    $rose(LED_RETURN_SWITCH) && !MAIN_POWER_SWITCH;
  endsequence
  sequence blanked;
    !MAIN_POWER_SWITCH [*4];
  endsequence
  AST_BLANK: assert property (led_close |=> blanked)
    else $error("main switch on inside blanking");
  AST_FAULT: assert property ((SENSE.undervoltage || SENSE.overtemp) [*5] |->
    !MAIN_POWER_SWITCH && !LED_RETURN_SWITCH && !ENABLED) else $error("fault not obeyed");
  AST_OVP: assert property (SENSE.overvoltage [*4] |-> !MAIN_POWER_SWITCH)
    else $error("main switch on in overvoltage");
  AST_PEAK: assert property (SENSE.peak_reached [*3] ##0 MAIN_POWER_SWITCH |->
    ##[1:2] !MAIN_POWER_SWITCH) else $error("main switch on past peak");
  AST_MAX_ON: assert property (on_q <= MAX_ON_CYC)
    else $error("main switch on too long");
  AST_MIN_OFF: assert property ($rose(MAIN_POWER_SWITCH) |-> off_q >= MIN_OFF_CYC)
    else $error("main switch off time too short");
  AST_IDLE: assert property (!ENABLED [*2] |->
    !LED_RETURN_SWITCH && SWITCH_CURRENT_LIMIT == LIM_OFF) else $error("idle not open");
  AST_START: assert property ($rose(ENABLED) |->
    SWITCH_CURRENT_LIMIT == LIM_QUARTER && !SOFTSTART_DONE) else $error("bad start");
  AST_DONE: assert property (SOFTSTART_DONE |->
    SWITCH_CURRENT_LIMIT == LIM_FULL && ENABLED) else $error("done without full limit");
  AST_FOLLOW: assert property (ENABLED [*4] |->
    LED_RETURN_SWITCH == $past(SENSE.ctrl, 3)) else $error("led switch not following");
endmodule
bind led_boost_ctrl led_boost_ctrl_assertions #(.EN_QUAL(EN_QUAL), .SHDN_QUAL(SHDN_QUAL),
  .BLANK(BLANK)) chk_i (.CLK(CLK), .RST(RST), .CE(CE), .SENSE(SENSE),
  .MAIN_POWER_SWITCH(MAIN_POWER_SWITCH), .LED_RETURN_SWITCH(LED_RETURN_SWITCH),
  .SWITCH_CURRENT_LIMIT(SWITCH_CURRENT_LIMIT), .ENABLED(ENABLED),
  .SOFTSTART_DONE(SOFTSTART_DONE));
`default_nettype wire

//--- led_host_src.sv
// host model: enable level or dimming waveform on the control input
`timescale 1ns/1ps
`default_nettype none
module led_host_src
(
  input  wire logic        clk,
  input  wire logic        run,    // low: line held low
  input  wire logic [15:0] hi_len, // high cycles per period
  input  wire logic [15:0] lo_len, // low cycles, zero for a steady high
  output logic             ctrl
);
  logic [15:0] cnt_q; // cycles in the present level
  // the caller keeps pulses long enough for the present phase
  always_ff @(posedge clk)
  begin
    if (!run)
    begin
      ctrl  <= 1'b0;
      cnt_q <= 16'h0000;
    end
    else if (ctrl ? (cnt_q + 16'h0001 >= hi_len && lo_len != 16'h0000)
                  : (cnt_q + 16'h0001 >= lo_len))
    begin
      ctrl  <= !ctrl;
      cnt_q <= 16'h0000;
    end
    else
      cnt_q <= cnt_q + 16'h0001;
  end
endmodule
`default_nettype wire

//--- led_boost_ctrl_tb.sv
// self-checking bench for the led boost enable and dimming control
`timescale 1ns/1ps
`default_nettype none
module led_boost_ctrl_tb
  import led_drv_pkg::*;
;
  localparam int EQ = 20;  // shortened enable qualification
  localparam int SQ = 200; // shortened shutdown qualification
  logic        clk;        // 100 MHz
  logic        rst;
  logic        ce;         // clock enable of the block
  logic        run;
  logic [15:0] hi_len;
  logic [15:0] lo_len;
  logic        host_ctrl;
  sense_t      s_q;        // comparator levels, ctrl comes from the host
  sense_t      sense_w;
  logic        main_sw;
  logic        led_sw;
  logic        en;
  logic        ss_done;
  logic [1:0]  lim;
  int          n_mismatch;
  int          checks_done;
  assign sense_w = {host_ctrl, s_q[4:0]};
  always #5 clk = ~clk;
  led_boost_ctrl #(.EN_QUAL(EQ), .SHDN_QUAL(SQ), .BLANK(4)) dut (.CLK(clk), .RST(rst),
    .CE(ce), .SENSE(sense_w), .MAIN_POWER_SWITCH(main_sw), .LED_RETURN_SWITCH(led_sw),
    .SWITCH_CURRENT_LIMIT(lim), .ENABLED(en), .SOFTSTART_DONE(ss_done));
  led_host_src host_i (.clk(clk), .run(run), .hi_len(hi_len), .lo_len(lo_len),
    .ctrl(host_ctrl));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one cycle, sampled once the edge has settled
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic host(input logic r, input logic [15:0] h, input logic [15:0] l);
    @(posedge clk);
    run <= r;
    hi_len <= h;
    lo_len <= l;
  endtask
  // bounded wait for the enable flag; a stuck flag ends the run
  task automatic wait_en(input logic lvl, output int n);
    for (n = 0; en !== lvl; n++)
    begin
      step();
      if (n > 20000)
      begin
        n_mismatch++;
        end_of_test();
      end
    end
  endtask
  // bounded wait for a host control level; a stuck host ends the run
  task automatic wait_host(input logic lvl);
    for (int n = 0; host_ctrl !== lvl; n++)
    begin
      step();
      if (n > 2000)
      begin
        n_mismatch++;
        end_of_test();
      end
    end
  endtask
  // length of the present main switch level, bounded
  task automatic run_len(input logic lvl, output int n);
    for (n = 0; main_sw === lvl; n++)
    begin
      step();
      if (n > 2000)
      begin
        n_mismatch++;
        end_of_test();
      end
    end
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_qual;
    int n;
    host(1'b1, 16'h000A, 16'h001E); // pulses shorter than qualification
    repeat (120) step();
    chk(en, 1'b0);
    host(1'b0, 16'h0000, 16'h0000);
    host(1'b1, 16'hFFFF, 16'h0000);
    step();
    wait_en(1'b1, n);
    chk(n >= EQ && n <= EQ + 6, 1'b1);
    chk(lim, LIM_QUARTER);
    chk(led_sw, 1'b1);
  endtask
  task automatic t_soft;
    int falls;
    int at_half;
    int at_full;
    logic pm;
    falls = 0;
    at_half = 0;
    at_full = 0;
    pm = 1'b0;
    @(posedge clk);
    s_q.feedback_low <= 1'b1;
    s_q.peak_reached <= 1'b1;
    repeat (40000)
    begin
      step();
      if (pm && !main_sw) falls++;
      pm = main_sw;
      if (lim === LIM_HALF && at_half == 0) at_half = falls;
      if (lim === LIM_FULL && at_full == 0) at_full = falls;
      if (ss_done === 1'b1) break;
    end
    chk(ss_done, 1'b1);
    chk(at_half, SS_STEP_CYCLES);
    chk(at_full, SS_DONE_CYCLES);
  endtask
  task automatic t_onoff;
    int n;
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    s_q.feedback_low <= 1'b0;
    s_q.peak_reached <= 1'b0;
    repeat (10) step();
    repeat (80)
    begin
      step();
      seen |= main_sw;
    end
    chk(seen, 1'b0);
    @(posedge clk);
    s_q.feedback_low <= 1'b1;
    run_len(1'b0, n);
    run_len(1'b1, n);
    chk(n >= MAX_ON_CYC - 1 && n <= MAX_ON_CYC + 1, 1'b1);
    run_len(1'b0, n);
    chk(n >= MIN_OFF_CYC, 1'b1);
  endtask
  task automatic t_ovp;
    int n;
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    s_q.peak_reached <= 1'b1;
    s_q.overvoltage <= 1'b1;
    repeat (8) step();
    repeat (100)
    begin
      step();
      seen |= main_sw;
    end
    chk(seen, 1'b0);
    @(posedge clk);
    s_q.overvoltage <= 1'b0;
    run_len(1'b0, n);
    chk(n < 100, 1'b1);
  endtask
  task automatic t_pwm;
    int n;
    int cr;
    int lr;
    logic pc;
    logic pl;
    cr = 0;
    lr = 0;
    host(1'b1, 16'd50, 16'd60); // past soft-start: pulses above the short limit
    repeat (10) step();
    pc = host_ctrl;
    pl = led_sw;
    repeat (550)
    begin
      step();
      if (host_ctrl && !pc) cr++;
      if (led_sw && !pl) lr++;
      pc = host_ctrl;
      pl = led_sw;
    end
    chk(lr, cr);
    chk(en, 1'b1);
    // stop only at the natural end of a high pulse, so the low time starts there
    wait_host(1'b1);
    wait_host(1'b0);
    host(1'b0, 16'h0000, 16'h0000);
    repeat (20) step();
    // 101 frozen edges stretch the shutdown qualification by as much
    @(posedge clk);
    ce <= 1'b0;
    repeat (100) step();
    chk(en, 1'b1);
    @(posedge clk);
    ce <= 1'b1;
    wait_en(1'b0, n);
    chk(n >= SQ - 22 && n <= SQ - 14, 1'b1);
    chk(led_sw, 1'b0);
  endtask
  task automatic t_fault;
    int n;
    for (int f = 0; f < 2; f++)
    begin
      host(1'b1, 16'hFFFF, 16'h0000);
      wait_en(1'b1, n);
      chk(n >= EQ, 1'b1);
      chk(lim, LIM_QUARTER);
      chk(ss_done, 1'b0);
      @(posedge clk);
      if (f == 1) s_q.overtemp <= 1'b1;
      else s_q.undervoltage <= 1'b1;
      repeat (6) step();
      chk({en, led_sw, main_sw}, 3'h0);
      repeat (3 * EQ) step();
      chk(en, 1'b0);
      @(posedge clk);
      s_q.overtemp <= 1'b0;
      s_q.undervoltage <= 1'b0;
    end
  endtask
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    run = 1'b0;
    hi_len = 16'h0000;
    lo_len = 16'h0000;
    s_q = '0;
    n_mismatch = 0;
    checks_done = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    step();
    t_qual();
    t_soft();
    t_onoff();
    t_ovp();
    t_pwm();
    t_fault();
    end_of_test();
  end
endmodule
`default_nettype wire
